// >>> litd_regs.sv
// receiver-detect / termination control and equalizer level registers for
// one input lane, with the automatic detection sequencer.
// assumes a byte-wide register port driven on clk by the serial management
// logic; the override bit lives in another register and arrives as a level.
`timescale 1ns/1ps
`default_nettype none
module litd_regs
    import litd_pkg::*;
#(
    parameter logic [TICK_W-1:0] INTERVAL = TICK_W'(INTERVAL_CYCLES)
) (
    input wire logic clk, // core clock, 100 MHz
    input wire logic rstn, // async reset, active low
    input wire logic [7:0] reg_addr, // register offset
    input wire logic reg_wr_en, // write strobe
    input wire logic [7:0] reg_wr_data, // write data
    input wire logic reg_rd_en, // read strobe
    output logic [7:0] reg_rd_data, // read data, one cycle after strobe
    input wire logic detect_pin_override, // override bit level
    input wire logic [1:0] receiver_detect_pin, // pin-selected mode, async
    input wire logic rx_present, // far receiver sensed, async
    output logic detect_test_pulse, // start one detection test
    output logic term_50ohm, // 1 = 50 ohm, 0 = hi-z
    output logic [7:0] equalizer_level // equalizer setting
);
    logic [1:0] receiver_detect_mode;
    logic [7:0] rsvd_after_eq;
    logic [7:0] rsvd_a;
    logic [7:0] rsvd_b;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic rx_meta;
    logic rx_sync;
    logic [1:0] eff_mode;
    logic [1:0] mode_prev;
    logic mode_change;
    logic tick;
    logic [5:0] attempts;
    logic bounded_done;
    litd_state_e state;
    litd_state_e next_state;
    logic next_test;

    // register writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            receiver_detect_mode <= RST_DETECT_MODE;
            equalizer_level <= RST_EQ_LEVEL;
            rsvd_after_eq <= RST_RSVD_AFTER_EQ;
            rsvd_a <= RST_RSVD_A;
            rsvd_b <= RST_RSVD_B;
        end else if (reg_wr_en) begin
            if (reg_addr == ADDR_RX_DETECT_CTRL) begin
                receiver_detect_mode <= reg_wr_data[MODE_MSB:MODE_LSB];
            end else if (reg_addr == ADDR_EQ_LEVEL) begin
                equalizer_level <= reg_wr_data;
            end else if (reg_addr == ADDR_RSVD_AFTER_EQ) begin
                rsvd_after_eq <= reg_wr_data;
            end else if (reg_addr == ADDR_RSVD_A) begin
                rsvd_a <= reg_wr_data;
            end else if (reg_addr == ADDR_RSVD_B) begin
                rsvd_b <= reg_wr_data;
            end
        end
    end

    // register reads; unused bits and unmapped offsets read zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            if (reg_addr == ADDR_RX_DETECT_CTRL) begin
                reg_rd_data <= {4'h0, receiver_detect_mode, 2'h0};
            end else if (reg_addr == ADDR_EQ_LEVEL) begin
                reg_rd_data <= equalizer_level;
            end else if (reg_addr == ADDR_RSVD_AFTER_EQ) begin
                reg_rd_data <= rsvd_after_eq;
            end else if (reg_addr == ADDR_RSVD_A) begin
                reg_rd_data <= rsvd_a;
            end else if (reg_addr == ADDR_RSVD_B) begin
                reg_rd_data <= rsvd_b;
            end else begin
                reg_rd_data <= 8'h00;
            end
        end
    end

    // pin and analog sense inputs come from outside the clock domain
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
        end else begin
            pin_meta <= receiver_detect_pin;
            pin_sync <= pin_meta;
            rx_meta <= rx_present;
            rx_sync <= rx_meta;
        end
    end

    // register field only counts while pin control is blocked
    assign eff_mode = detect_pin_override ? receiver_detect_mode
                                          : pin_sync;
    assign mode_change = (eff_mode != mode_prev);
    assign bounded_done = (mode_prev == MODE_AUTO_BOUNDED) &&
                          (attempts == MAX_ATTEMPTS);

    litd_tick #(
        .PERIOD_CYCLES(INTERVAL)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    always_comb begin
        next_state = state;
        if (mode_change) begin
            case (eff_mode)
                MODE_HIZ: next_state = st_hiz;
                MODE_FIXED_50: next_state = st_fixed;
                default: next_state = st_testing;
            endcase
        end else if (state == st_testing) begin
            if (rx_sync) begin
                next_state = st_detected;
            end else if (tick && bounded_done) begin
                next_state = st_gave_up;
            end
        end
    end

    // a fresh test only when no result has come and the budget allows
    assign next_test = !mode_change && (state == st_testing) && tick &&
                       !rx_sync && !bounded_done;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= st_hiz;
            mode_prev <= RST_DETECT_MODE;
        end else begin
            state <= next_state;
            mode_prev <= eff_mode;
        end
    end

    // attempt counter saturates at the cap; unbounded mode ignores it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            attempts <= 6'h00;
            detect_test_pulse <= 1'b0;
        end else begin
            detect_test_pulse <= next_test;
            if (mode_change) begin
                attempts <= 6'h00;
            end else if (next_test && attempts != MAX_ATTEMPTS) begin
                attempts <= attempts + 6'h01;
            end
        end
    end

    assign term_50ohm = (state == st_detected) || (state == st_fixed);

    sequence s_eq_write;
        reg_wr_en && reg_addr == ADDR_EQ_LEVEL;
    endsequence
    sequence s_eq_read;
        reg_rd_en && !reg_wr_en && reg_addr == ADDR_EQ_LEVEL;
    endsequence

    a_eq_readback: assert property (@(posedge clk) disable iff (!rstn)
        s_eq_write ##1 s_eq_read |=> reg_rd_data == $past(reg_wr_data, 2))
        else $error("equalizer level read back wrong");
    a_hiz_mode: assert property (@(posedge clk) disable iff (!rstn)
        eff_mode == MODE_HIZ |=> !term_50ohm)
        else $error("hi-z mode shows termination");
    a_fixed_mode: assert property (@(posedge clk) disable iff (!rstn)
        eff_mode == MODE_FIXED_50 |=> term_50ohm && !detect_test_pulse)
        else $error("fixed mode lacks termination or tests");
    a_auto_hiz: assert property (@(posedge clk) disable iff (!rstn)
        mode_change && (eff_mode == MODE_AUTO_BOUNDED ||
        eff_mode == MODE_AUTO_UNBOUNDED) |=> !term_50ohm)
        else $error("termination before detection");
    a_detect_term: assert property (@(posedge clk) disable iff (!rstn)
        state == st_testing && rx_sync && !mode_change |=> term_50ohm)
        else $error("detection did not enable termination");
    a_bounded_stop: assert property (@(posedge clk) disable iff (!rstn)
        state == st_testing && tick && !rx_sync && !mode_change &&
        eff_mode == MODE_AUTO_BOUNDED && attempts == MAX_ATTEMPTS
        |=> state == st_gave_up && !detect_test_pulse)
        else $error("bounded mode did not stop after last test");
    a_unbounded_run: assert property (@(posedge clk) disable iff (!rstn)
        state == st_testing && tick && !rx_sync && !mode_change &&
        eff_mode == MODE_AUTO_UNBOUNDED
        |=> detect_test_pulse && state == st_testing)
        else $error("unbounded mode stopped testing");
    a_attempt_cap: assert property (@(posedge clk) disable iff (!rstn)
        detect_test_pulse && mode_prev == MODE_AUTO_BOUNDED
        |-> attempts <= MAX_ATTEMPTS && attempts != 6'h00)
        else $error("attempt count out of range");
    a_pin_control: assert property (@(posedge clk) disable iff (!rstn)
        !detect_pin_override && pin_sync == MODE_HIZ ##1
        !detect_pin_override && pin_sync == MODE_HIZ |-> !term_50ohm)
        else $error("register field used without override");
    a_reg_control: assert property (@(posedge clk) disable iff (!rstn)
        detect_pin_override && receiver_detect_mode == MODE_FIXED_50
        |=> term_50ohm)
        else $error("register field ignored under override");
    a_pulse_single: assert property (@(posedge clk) disable iff (!rstn)
        detect_test_pulse |=> !detect_test_pulse)
        else $error("detection test pulse wider than one cycle");
    a_gave_up_quiet: assert property (@(posedge clk) disable iff (!rstn)
        state == st_gave_up |-> !detect_test_pulse && !term_50ohm)
        else $error("bounded mode still testing after giving up");
    a_detect_hold: assert property (@(posedge clk) disable iff (!rstn)
        term_50ohm && !mode_change |=> term_50ohm)
        else $error("termination dropped without a mode change");
endmodule : litd_regs
`default_nettype wire

// >>> litd_pkg.sv
// constants for the lane input termination / receiver-detect register block
// assumes a 100 MHz core clock and a byte-wide internal register port
package litd_pkg;
    // register offsets
    localparam logic [7:0] ADDR_RX_DETECT_CTRL = 8'h0e;
    localparam logic [7:0] ADDR_EQ_LEVEL = 8'h0f;
    localparam logic [7:0] ADDR_RSVD_AFTER_EQ = 8'h10;
    localparam logic [7:0] ADDR_RSVD_A = 8'h11;
    localparam logic [7:0] ADDR_RSVD_B = 8'h12;
    // field layout of the detect control register
    localparam int MODE_LSB = 2;
    localparam int MODE_MSB = 3;
    // reset values
    localparam logic [1:0] RST_DETECT_MODE = 2'h0;
    localparam logic [7:0] RST_EQ_LEVEL = 8'h2f;
    localparam logic [7:0] RST_RSVD_AFTER_EQ = 8'had;
    localparam logic [7:0] RST_RSVD_A = 8'h02;
    localparam logic [7:0] RST_RSVD_B = 8'h00;
    // mode codes
    localparam logic [1:0] MODE_HIZ = 2'h0;
    localparam logic [1:0] MODE_AUTO_BOUNDED = 2'h1;
    localparam logic [1:0] MODE_AUTO_UNBOUNDED = 2'h2;
    localparam logic [1:0] MODE_FIXED_50 = 2'h3;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DETECT_INTERVAL_MS = 12;
    localparam int DETECT_WINDOW_MS = 600;
    localparam int INTERVAL_CYCLES =
        DETECT_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [5:0] MAX_ATTEMPTS =
        6'(DETECT_WINDOW_MS / DETECT_INTERVAL_MS);
    localparam int TICK_W = 21;
    typedef enum logic [2:0] {
        st_hiz, st_fixed, st_testing, st_detected, st_gave_up
    } litd_state_e;
endpackage : litd_pkg

// >>> litd_tick.sv
// free-running interval timer: one-cycle tick every period_cycles clocks
// assumes period_cycles fits in the counter width of the package
`timescale 1ns/1ps
`default_nettype none
module litd_tick
    import litd_pkg::*;
#(
    parameter logic [TICK_W-1:0] PERIOD_CYCLES = TICK_W'(INTERVAL_CYCLES)
) (
    input wire logic clk, // core clock
    input wire logic rstn, // async reset, active low
    output logic tick // one-cycle pulse per interval
);
    logic [TICK_W-1:0] cnt;

    // free-running so the interval needs no restart handshake
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (cnt == PERIOD_CYCLES - TICK_W'(1)) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + TICK_W'(1);
            tick <= 1'b0;
        end
    end
endmodule : litd_tick
`default_nettype wire

// >>> litd_regs_tb_top.sv
// self-checking bench for the lane detect / equalizer register block
// assumes litd_regs with a short detect interval; bench drives all ports
`timescale 1ns/1ps
`default_nettype none
module litd_regs_tb_top;
    import litd_pkg::*;
    localparam int IVL = 20;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} litd_row_s;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_rd_data;
    logic detect_pin_override = 1'b1;
    logic [1:0] receiver_detect_pin = 2'h0;
    logic rx_present = 1'b0;
    logic detect_test_pulse;
    logic term_50ohm;
    logic [7:0] equalizer_level;
    int fail_count = 0;
    int checks_done = 0;
    int pulses = 0;
    int cycles = 0;
    litd_row_s rows [7] = '{'{8'h0f, 8'h55, 8'h55}, '{8'h0f, 8'hff, 8'hff},
        '{8'h0f, 8'h00, 8'h00}, '{8'h0e, 8'hff, 8'h0c},
        '{8'h0e, 8'h00, 8'h00}, '{8'h10, 8'h12, 8'h12},
        '{8'h20, 8'h5a, 8'h00}};

    litd_regs #(.INTERVAL(TICK_W'(IVL))) DUT (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .detect_pin_override(detect_pin_override),
        .receiver_detect_pin(receiver_detect_pin), .rx_present(rx_present),
        .detect_test_pulse(detect_test_pulse), .term_50ohm(term_50ohm),
        .equalizer_level(equalizer_level));

    initial begin
        forever #5 clk = ~clk;
    end

    // pulses are one cycle wide, so each edge seen high is one test
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (detect_test_pulse === 1'b1) pulses <= pulses + 1;
        if (cycles == 8000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        chk(reg_rd_data, exp);
    endtask : rd

    // set a register mode, then count tests over n detect intervals
    task automatic run_mode(input logic [1:0] m, input int n);
        wr(8'h0e, {4'h0, m, 2'h0});
        pulses = 0;
        repeat (n * IVL) @(negedge clk);
    endtask : run_mode

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        chk(equalizer_level, 8'h00);
        $display("register table done");
        @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        chk(equalizer_level, 8'h2f);
        rstn = 1'b1;
        rd(8'h0e, 8'h00);
        rd(8'h0f, 8'h2f);
        rd(8'h10, 8'had);
        rd(8'h11, 8'h02);
        rd(8'h12, 8'h00);
        chk({7'h0, term_50ohm}, 8'h00);
        $display("reset values done");
        // write then read on the very next edge, as the port allows
        @(negedge clk);
        reg_addr = 8'h0f;
        reg_wr_data = 8'h3c;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        chk(reg_rd_data, 8'h3c);
        chk(equalizer_level, 8'h3c);
        $display("back to back access done");
        run_mode(MODE_FIXED_50, 3);
        chk({7'h0, term_50ohm}, 8'h01);
        chk(pulses[7:0], 8'h00);
        run_mode(MODE_HIZ, 1);
        chk({7'h0, term_50ohm}, 8'h00);
        run_mode(MODE_AUTO_BOUNDED, 60);
        chk(pulses[7:0], 8'h32);
        chk({7'h0, term_50ohm}, 8'h00);
        $display("bounded mode done");
        run_mode(MODE_AUTO_UNBOUNDED, 60);
        chk({7'h0, 1'(pulses > 50)}, 8'h01);
        chk({7'h0, term_50ohm}, 8'h00);
        rx_present = 1'b1;
        repeat (5) @(negedge clk);
        chk({7'h0, term_50ohm}, 8'h01);
        pulses = 0;
        repeat (3 * IVL) @(negedge clk);
        chk(pulses[7:0], 8'h00);
        rx_present = 1'b0;
        $display("unbounded mode done");
        // override low: pin code rules, register field ignored
        run_mode(MODE_HIZ, 1);
        receiver_detect_pin = MODE_FIXED_50;
        detect_pin_override = 1'b0;
        repeat (6) @(negedge clk);
        chk({7'h0, term_50ohm}, 8'h01);
        wr(8'h0e, 8'h00);
        repeat (3) @(negedge clk);
        chk({7'h0, term_50ohm}, 8'h01);
        detect_pin_override = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h0, term_50ohm}, 8'h00);
        // register asks for 50 ohm, pin asks for hi-z: pin must win
        wr(8'h0e, {4'h0, MODE_FIXED_50, 2'h0});
        repeat (2) @(negedge clk);
        chk({7'h0, term_50ohm}, 8'h01);
        receiver_detect_pin = MODE_HIZ;
        detect_pin_override = 1'b0;
        repeat (6) @(negedge clk);
        chk({7'h0, term_50ohm}, 8'h00);
        detect_pin_override = 1'b1;
        $display("override done");
        complete_run();
    end
endmodule : litd_regs_tb_top
`default_nettype wire
